//--- rtl/rsc_params.svh
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_CLK_HZ        100000000
`define RSC_RC_HZ         31250
`define RSC_PUT_MS        64
`define RSC_PUT_CYCLES    ((`RSC_RC_HZ * `RSC_PUT_MS) / 1000)
`define RSC_WDT_TICKS     16384
`define RSC_OFS_PRF       8'h8e
`define RSC_OFS_STATUS    8'h03
`define RSC_OFS_PC_LO     8'h02
`define RSC_OFS_PC_HI     8'h0a
`define RSC_OFS_IRQ_STAT  8'h90
`define RSC_OFS_IRQ_MASK  8'h91
`define RSC_BIT_BOR       0
`define RSC_BIT_POR       1
`define RSC_BIT_PD        3
`define RSC_BIT_TO        4
`define RSC_PC_RESET      13'h0000
`define RSC_PC_VECTOR     13'h0004
`define RSC_STATUS_POR    8'h18
`define RSC_IRQ_W         4
`define RSC_IRQ_RESET     0
`define RSC_IRQ_WAKE      1
`define RSC_IRQ_START     2
`define RSC_IRQ_VECT      3
`endif

//--- rtl/rsc_pkg.sv
package rsc_pkg;
	typedef enum logic [1:0] {
		RSC_HOLD,
		RSC_TIMING,
		RSC_WAIT_PIN,
		RSC_RUN
	} rsc_state_e;
	typedef logic [12:0] rsc_pc_t;
endpackage

//--- rtl/rsc_reset_seq.sv
`include "rsc_params.svh"
module rsc_reset_seq
	import rsc_pkg::*;
#(
	parameter int PUT_CYCLES = `RSC_PUT_CYCLES,
	parameter int WDT_TICKS  = `RSC_WDT_TICKS
) (
	input  wire logic         CLOCK,
	input  wire logic         ARST_N,
	input  wire logic         RC_TICK,
	input  wire logic         POWER_OK,
	input  wire logic         BROWNOUT,
	input  wire logic         OSC_READY,
	input  wire logic         MASTER_CLEAR_PIN_N,
	input  wire logic         EXT_RESET_PIN_ENABLE,
	input  wire logic         POWERUP_TIMER_DISABLE,
	input  wire logic         WATCHDOG_ENABLE,
	input  wire logic         WATCHDOG_KICK_INSTR,
	input  wire logic         SLEEP_ACTIVE,
	input  wire logic         IRQ_WAKE,
	input  wire logic         GLOBAL_IRQ_ENABLE,
	input  wire logic         STEP_DONE,
	input  wire logic [12:0]  PC_IN,
	output logic              CHIP_RESET,
	output logic              PC_LOAD,
	output logic [12:0]       PC_VALUE,
	output logic              IRQ_PUSH,
	input  wire logic         WB_CYC_I,
	input  wire logic         WB_STB_I,
	input  wire logic         WB_WE_I,
	input  wire logic [7:0]   WB_ADR_I,
	input  wire logic [3:0]   WB_SEL_I,
	input  wire logic [31:0]  WB_DAT_I,
	output logic [31:0]       WB_DAT_O,
	output logic              WB_ACK_O,
	output logic              IRQ
);
	////////////////////////////////////////////////////////////////////
	localparam int PW = $clog2(PUT_CYCLES + 1);
	localparam int WW = $clog2(WDT_TICKS + 1);
	rsc_state_e        state;
	rsc_state_e        next_state;
	logic [PW-1:0]     put_cnt;
	logic [WW-1:0]     wdt_cnt;
	logic              por_seen;
	logic [1:0]        prf;
	logic [7:0]        status;
	logic              vect_pend;
	logic [`RSC_IRQ_W-1:0] irq_stat;
	logic [`RSC_IRQ_W-1:0] irq_mask;
	// Pin reset only counts when the pin is enabled as reset input.
	wire pin_low     = EXT_RESET_PIN_ENABLE & ~MASTER_CLEAR_PIN_N;
	wire bor_ev      = BROWNOUT & por_seen;
	wire supply_bad  = ~POWER_OK | BROWNOUT;
	wire put_done    = POWERUP_TIMER_DISABLE ||
	                   (put_cnt == PW'(PUT_CYCLES));
	wire wdt_expire  = WATCHDOG_ENABLE && state == RSC_RUN &&
	                   RC_TICK && wdt_cnt == WW'(WDT_TICKS - 1);
	wire wdt_wake    = wdt_expire & SLEEP_ACTIVE;
	wire wdt_reset   = wdt_expire & ~SLEEP_ACTIVE;
	wire irq_wake_ev = state == RSC_RUN && SLEEP_ACTIVE && IRQ_WAKE &&
	                   !wdt_expire;
	wire pin_ev      = state == RSC_RUN && pin_low;
	wire started     = state != RSC_RUN && next_state == RSC_RUN;
	////////////////////////////////////////////////////////////////////
	// Sequencer: power and brown-out abort to hold; run needs all three.
	always_comb begin
		next_state = state;
		unique case (state)
			RSC_HOLD:     if (!supply_bad) next_state = RSC_TIMING;
			RSC_TIMING:   if (put_done && OSC_READY)
				next_state = pin_low ? RSC_WAIT_PIN : RSC_RUN;
			RSC_WAIT_PIN: if (!pin_low) next_state = RSC_RUN;
			RSC_RUN:      if (pin_low || wdt_reset) next_state = RSC_WAIT_PIN;
		endcase
		if (supply_bad) next_state = RSC_HOLD;
	end
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) state <= RSC_HOLD;
		else state <= next_state;
	end
	assign CHIP_RESET = state != RSC_RUN;
	// Delay counter advances only on the RC oscillator tick.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) put_cnt <= '0;
		else if (state == RSC_HOLD || supply_bad)
			put_cnt <= '0;
		else if (state == RSC_TIMING && RC_TICK && !put_done)
			put_cnt <= put_cnt + PW'(1);
	end
	// The delay runs after power-up and brown-out; pin and watchdog resets skip it.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) por_seen <= 1'b0;
		else if (~POWER_OK) por_seen <= 1'b0;
		else if (started) por_seen <= 1'b1;
	end
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) wdt_cnt <= '0;
		else if (state != RSC_RUN || WATCHDOG_KICK_INSTR || wdt_expire)
			wdt_cnt <= '0;
		else if (RC_TICK) wdt_cnt <= wdt_cnt + WW'(1);
	end
	////////////////////////////////////////////////////////////////////
	wire bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire wr_lane0 = bus_req & WB_WE_I & WB_SEL_I[0];
	wire wr_prf   = wr_lane0 && WB_ADR_I == `RSC_OFS_PRF;
	wire wr_stat  = wr_lane0 && WB_ADR_I == `RSC_OFS_STATUS;
	wire wr_istat = wr_lane0 && WB_ADR_I == `RSC_OFS_IRQ_STAT;
	wire wr_imask = wr_lane0 && WB_ADR_I == `RSC_OFS_IRQ_MASK;
	wire [7:0] rd_mux =
		WB_ADR_I == `RSC_OFS_PRF      ? {6'h00, prf} :
		WB_ADR_I == `RSC_OFS_STATUS   ? status :
		WB_ADR_I == `RSC_OFS_PC_LO    ? PC_VALUE[7:0] :
		WB_ADR_I == `RSC_OFS_PC_HI    ? {3'h0, PC_VALUE[12:8]} :
		WB_ADR_I == `RSC_OFS_IRQ_STAT ? {4'h0, irq_stat} :
		WB_ADR_I == `RSC_OFS_IRQ_MASK ? {4'h0, irq_mask} : 8'h00;
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= bus_req;
			WB_DAT_O <= {24'h000000, rd_mux};
		end
	end
	////////////////////////////////////////////////////////////////////
	// Reset-cause flags: hardware events win over software writes.
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			prf    <= 2'b00;
			status <= `RSC_STATUS_POR;
		end else if (~POWER_OK) begin
			prf[`RSC_BIT_POR] <= 1'b0;
			status <= `RSC_STATUS_POR;
		end else if (bor_ev) begin
			prf[`RSC_BIT_BOR] <= 1'b0;
			status <= `RSC_STATUS_POR;
		end else if (wdt_reset) begin
			status[7:4] <= 4'h0;
		end else if (wdt_wake) begin
			status[`RSC_BIT_TO] <= 1'b0;
			status[`RSC_BIT_PD] <= 1'b0;
		end else if (pin_ev) begin
			status[7:5] <= 3'h0;
			if (SLEEP_ACTIVE) begin
				status[`RSC_BIT_TO] <= 1'b1;
				status[`RSC_BIT_PD] <= 1'b0;
			end
		end else if (irq_wake_ev) begin
			status[`RSC_BIT_TO] <= 1'b1;
			status[`RSC_BIT_PD] <= 1'b0;
		end else begin
			if (wr_prf) prf <= WB_DAT_I[1:0];
			if (wr_stat) status <= WB_DAT_I[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////
	// Program counter load: zero on resets, next on wakes, then vector.
	wire reset_load = started;
	wire wake_load  = wdt_wake | irq_wake_ev;
	wire vect_load  = vect_pend & STEP_DONE;
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PC_LOAD   <= 1'b0;
			PC_VALUE  <= `RSC_PC_RESET;
			IRQ_PUSH  <= 1'b0;
			vect_pend <= 1'b0;
		end else begin
			PC_LOAD  <= reset_load | wake_load | vect_load;
			IRQ_PUSH <= vect_load;
			if (reset_load) PC_VALUE <= `RSC_PC_RESET;
			else if (wake_load) PC_VALUE <= PC_IN + 13'h0001;
			else if (vect_load) PC_VALUE <= `RSC_PC_VECTOR;
			if (reset_load) vect_pend <= 1'b0;
			else if (irq_wake_ev && GLOBAL_IRQ_ENABLE) vect_pend <= 1'b1;
			else if (vect_load) vect_pend <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////
	wire [`RSC_IRQ_W-1:0] irq_ev = {vect_load, started,
	                                wake_load, wdt_reset | pin_ev | bor_ev};
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else begin
			irq_stat <= irq_ev | (irq_stat &
			            ~(wr_istat ? WB_DAT_I[`RSC_IRQ_W-1:0] : '0));
			if (wr_imask) irq_mask <= WB_DAT_I[`RSC_IRQ_W-1:0];
		end
	end
	assign IRQ = |(irq_stat & irq_mask);
	////////////////////////////////////////////////////////////////////
	property p_hold_while_timing;
		@(posedge CLOCK) disable iff (!ARST_N)
		state == RSC_TIMING |-> CHIP_RESET;
	endproperty
	a_hold_while_timing: assert property (p_hold_while_timing)
		else $error("chip released while delay timer counts");
	property p_no_run_early;
		@(posedge CLOCK) disable iff (!ARST_N)
		$rose(state == RSC_RUN) && $past(state) == RSC_TIMING |->
			$past(put_done) && $past(OSC_READY);
	endproperty
	a_no_run_early: assert property (p_no_run_early)
		else $error("run began before timers completed");
	property p_bor_restart;
		@(posedge CLOCK) disable iff (!ARST_N)
		BROWNOUT |=> put_cnt == '0;
	endproperty
	a_bor_restart: assert property (p_bor_restart)
		else $error("brown-out did not restart delay");
	property p_disable_nodelay;
		@(posedge CLOCK) disable iff (!ARST_N)
		state == RSC_TIMING && POWERUP_TIMER_DISABLE && OSC_READY &&
		!supply_bad && !pin_low |=> state == RSC_RUN;
	endproperty
	a_disable_nodelay: assert property (p_disable_nodelay)
		else $error("disabled timer still delayed start");
	property p_pin_release;
		@(posedge CLOCK) disable iff (!ARST_N)
		state == RSC_WAIT_PIN && !pin_low && !supply_bad |=> !CHIP_RESET;
	endproperty
	a_pin_release: assert property (p_pin_release)
		else $error("pin release did not start execution");
	property p_por_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		!POWER_OK |=> !prf[`RSC_BIT_POR] && status[4:3] == 2'b11;
	endproperty
	a_por_flags: assert property (p_por_flags)
		else $error("power-on flags wrong");
	property p_wdt_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		wdt_reset && POWER_OK && !bor_ev |=>
			status[7:4] == 4'h0 && $stable(status[3:0]);
	endproperty
	a_wdt_flags: assert property (p_wdt_flags)
		else $error("watchdog reset status wrong");
	property p_wake_pc;
		@(posedge CLOCK) disable iff (!ARST_N)
		wake_load && !reset_load |=> PC_LOAD &&
			PC_VALUE == $past(PC_IN) + 13'h0001;
	endproperty
	a_wake_pc: assert property (p_wake_pc)
		else $error("wake did not load next pc");
	property p_prf_upper;
		@(posedge CLOCK) disable iff (!ARST_N)
		WB_ACK_O && $past(WB_ADR_I) == `RSC_OFS_PRF |->
			WB_DAT_O[7:2] == 6'h00;
	endproperty
	a_prf_upper: assert property (p_prf_upper)
		else $error("power flag upper bits not zero");

	// The checks below pin down the cause flags, the program counter loads
	// and the timer behaviour for every kind of reset and wake-up, except the power-on and watchdog-reset flags and the wake load checked above.
	// Each one excludes the higher-priority events that may legally
	// override it in the same cycle, except p_flag_write, which leaves out
	// the watchdog, pin and wake events.

	property p_put_tick;
		@(posedge CLOCK) disable iff (!ARST_N)
		state == RSC_TIMING && !RC_TICK && !supply_bad |=> $stable(put_cnt);
	endproperty
	a_put_tick: assert property (p_put_tick)
		else $error("delay counter moved without an oscillator tick");

	property p_put_limit;
		@(posedge CLOCK) disable iff (!ARST_N)
		put_cnt <= PW'(PUT_CYCLES);
	endproperty
	a_put_limit: assert property (p_put_limit)
		else $error("delay counter ran past its end");

	property p_por_delay;
		@(posedge CLOCK) disable iff (!ARST_N)
		state == RSC_TIMING && !POWERUP_TIMER_DISABLE && !put_done |=>
			state != RSC_RUN;
	endproperty
	a_por_delay: assert property (p_por_delay)
		else $error("run began before the delay ended");

	property p_pc_zero_start;
		@(posedge CLOCK) disable iff (!ARST_N)
		started |=> PC_LOAD && PC_VALUE == `RSC_PC_RESET;
	endproperty
	a_pc_zero_start: assert property (p_pc_zero_start)
		else $error("start did not load address zero");

	property p_bor_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		bor_ev && POWER_OK |=>
			!prf[`RSC_BIT_BOR] && status == `RSC_STATUS_POR;
	endproperty
	a_bor_flags: assert property (p_bor_flags)
		else $error("brown-out flags wrong");

	property p_pin_sleep_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		pin_ev && SLEEP_ACTIVE && !supply_bad && !wdt_expire |=>
			status[7:5] == 3'h0 && status[4:3] == 2'b10;
	endproperty
	a_pin_sleep_flags: assert property (p_pin_sleep_flags)
		else $error("pin reset in sleep flags wrong");

	property p_pin_run_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		pin_ev && !SLEEP_ACTIVE && !supply_bad && !wdt_expire |=>
			status[7:5] == 3'h0 && $stable(status[4:0]);
	endproperty
	a_pin_run_flags: assert property (p_pin_run_flags)
		else $error("pin reset in run changed flags");

	property p_wdt_wake_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		wdt_wake && !supply_bad |=> status[4:3] == 2'b00;
	endproperty
	a_wdt_wake_flags: assert property (p_wdt_wake_flags)
		else $error("watchdog wake flags wrong");

	property p_irq_wake_flags;
		@(posedge CLOCK) disable iff (!ARST_N)
		irq_wake_ev && !supply_bad && !pin_ev |=> status[4:3] == 2'b10;
	endproperty
	a_irq_wake_flags: assert property (p_irq_wake_flags)
		else $error("interrupt wake flags wrong");

	property p_vector;
		@(posedge CLOCK) disable iff (!ARST_N)
		vect_load && !reset_load && !wake_load |=>
			IRQ_PUSH && PC_VALUE == `RSC_PC_VECTOR;
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector jump missing");

	property p_pin_ignored;
		@(posedge CLOCK) disable iff (!ARST_N)
		!EXT_RESET_PIN_ENABLE && state == RSC_RUN && !supply_bad &&
			!wdt_reset |=> !CHIP_RESET;
	endproperty
	a_pin_ignored: assert property (p_pin_ignored)
		else $error("disabled pin still reset the chip");

	property p_wdt_expire;
		@(posedge CLOCK) disable iff (!ARST_N)
		wdt_reset |=> CHIP_RESET;
	endproperty
	a_wdt_expire: assert property (p_wdt_expire)
		else $error("watchdog expiry did not reset");

	property p_cause_irq;
		@(posedge CLOCK) disable iff (!ARST_N)
		wdt_reset |=> irq_stat[`RSC_IRQ_RESET];
	endproperty
	a_cause_irq: assert property (p_cause_irq)
		else $error("reset event not recorded");

	property p_flag_write;
		@(posedge CLOCK) disable iff (!ARST_N)
		wr_prf && !supply_bad |=> prf == $past(WB_DAT_I[1:0]);
	endproperty
	a_flag_write: assert property (p_flag_write)
		else $error("power flag write lost");
endmodule

//--- verification/rsc_reset_seq_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, arst_n, rc_tick, power_ok, brownout, osc_ready;
	logic        master_clear_pin_n, ext_reset_pin_enable, wd_en, sleep;
	logic        powerup_timer_disable, watchdog_kick_instr, wake, step;
	logic        global_irq_enable, chip_reset, pc_load, irq_push, irq;
	logic        cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [31:0] dat_i, dat_o;
	logic [12:0] pc_value;
	int          n_errors, comparisons;

	rsc_reset_seq #(.PUT_CYCLES(8), .WDT_TICKS(16)) rsc_reset_seq_inst (
		.CLOCK(clock), .ARST_N(arst_n), .RC_TICK(rc_tick),
		.POWER_OK(power_ok), .BROWNOUT(brownout), .OSC_READY(osc_ready),
		.MASTER_CLEAR_PIN_N(master_clear_pin_n),
		.EXT_RESET_PIN_ENABLE(ext_reset_pin_enable),
		.POWERUP_TIMER_DISABLE(powerup_timer_disable),
		.WATCHDOG_ENABLE(wd_en), .WATCHDOG_KICK_INSTR(watchdog_kick_instr),
		.SLEEP_ACTIVE(sleep), .IRQ_WAKE(wake),
		.GLOBAL_IRQ_ENABLE(global_irq_enable), .STEP_DONE(step),
		.PC_IN(13'h0123), .CHIP_RESET(chip_reset), .PC_LOAD(pc_load),
		.PC_VALUE(pc_value), .IRQ_PUSH(irq_push), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
		.WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk({31'h0, ack}, 32'h1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk({24'h000000, q}, {24'h000000, exp});
	endtask

	// Each tick is a one-cycle pulse; a short gap lets the state settle.
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clock);
			rc_tick <= 1'b1;
			@(posedge clock);
			rc_tick <= 1'b0;
		end
		repeat (3) @(posedge clock);
	endtask

	task automatic wait_run(input int lim);
		int n;
		n = 0;
		while (chip_reset !== 1'b0 && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, chip_reset}, 32'h0);
		n = 0;
		while (pc_load !== 1'b1 && n < 4) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, pc_load}, 32'h1);
		chk({19'h0, pc_value}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_power_on;
		chk({31'h0, chip_reset}, 32'h1);
		rd_chk(8'h03, 8'h18);
		rd_chk(8'h8e, 8'h00);
		power_ok <= 1'b1;
		ticks(5);
		brownout <= 1'b1;
		repeat (2) @(posedge clock);
		brownout <= 1'b0;
		ticks(7);
		chk({31'h0, chip_reset}, 32'h1);
		ticks(1);
		chk({31'h0, chip_reset}, 32'h1);
		osc_ready <= 1'b1;
		wait_run(10);
	endtask

	task automatic t_regs;
		wr(8'h8e, 8'hff);
		rd_chk(8'h8e, 8'h03);
		wr(8'h55, 8'hff);
		rd_chk(8'h55, 8'h00);
	endtask

	// The oscillator is held back so that the start pulse is seen here.
	task automatic t_brownout;
		osc_ready <= 1'b0;
		brownout <= 1'b1;
		repeat (3) @(posedge clock);
		brownout <= 1'b0;
		ticks(7);
		chk({31'h0, chip_reset}, 32'h1);
		ticks(1);
		chk({31'h0, chip_reset}, 32'h1);
		osc_ready <= 1'b1;
		wait_run(10);
		rd_chk(8'h8e, 8'h02);
		rd_chk(8'h03, 8'h18);
	endtask

	task automatic t_disable;
		powerup_timer_disable <= 1'b1;
		power_ok <= 1'b0;
		repeat (3) @(posedge clock);
		power_ok <= 1'b1;
		wait_run(20);
		rd_chk(8'h8e, 8'h00);
		powerup_timer_disable <= 1'b0;
	endtask

	task automatic t_late_pin;
		master_clear_pin_n <= 1'b0;
		power_ok <= 1'b0;
		repeat (3) @(posedge clock);
		power_ok <= 1'b1;
		ticks(8);
		chk({31'h0, chip_reset}, 32'h1);
		master_clear_pin_n <= 1'b1;
		wait_run(3);
	endtask

	task automatic t_pin_reset;
		for (int i = 0; i < 2; i++) begin
			sleep <= i[0];
			wr(8'h03, 8'hff);
			master_clear_pin_n <= 1'b0;
			repeat (3) @(posedge clock);
			master_clear_pin_n <= 1'b1;
			sleep <= 1'b0;
			wait_run(10);
			rd_chk(8'h03, i[0] ? 8'h17 : 8'h1f);
		end
		ext_reset_pin_enable <= 1'b0;
		master_clear_pin_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk({31'h0, chip_reset}, 32'h0);
		master_clear_pin_n <= 1'b1;
		ext_reset_pin_enable <= 1'b1;
		chk({31'h0, irq}, 32'h0);
		wr(8'h91, 8'h01);
		chk({31'h0, irq}, 32'h1);
		wr(8'h90, 8'h01);
		chk({31'h0, irq}, 32'h0);
		wr(8'h91, 8'h00);
	endtask

	task automatic t_watchdog;
		wd_en <= 1'b1;
		wr(8'h03, 8'hff);
		ticks(10);
		watchdog_kick_instr <= 1'b1;
		@(posedge clock);
		watchdog_kick_instr <= 1'b0;
		ticks(10);
		rd_chk(8'h03, 8'hff);
		ticks(10);
		rd_chk(8'h03, 8'h0f);
		wr(8'h03, 8'hff);
		sleep <= 1'b1;
		ticks(17);
		rd_chk(8'h03, 8'he7);
		sleep <= 1'b0;
		wd_en <= 1'b0;
	endtask

	task automatic t_irq_wake;
		int n;
		n = 0;
		global_irq_enable <= 1'b1;
		wr(8'h03, 8'hff);
		sleep <= 1'b1;
		wake <= 1'b1;
		repeat (2) @(posedge clock);
		wake <= 1'b0;
		sleep <= 1'b0;
		rd_chk(8'h03, 8'hf7);
		step <= 1'b1;
		@(posedge clock);
		step <= 1'b0;
		while (irq_push !== 1'b1 && n < 8) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, irq_push}, 32'h1);
		chk({19'h0, pc_value}, 32'h4);
	endtask

	task automatic report_and_stop;
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		n_errors = 0;
		comparisons = 0;
		{arst_n, rc_tick, power_ok, brownout, osc_ready, wd_en, sleep,
			powerup_timer_disable, watchdog_kick_instr, wake, step,
			global_irq_enable, cyc, stb, we} = '0;
		master_clear_pin_n = 1'b1;
		ext_reset_pin_enable = 1'b1;
		adr = 8'h00;
		dat_i = 32'h0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		t_power_on();
		t_regs();
		t_brownout();
		t_disable();
		t_late_pin();
		t_pin_reset();
		t_watchdog();
		t_irq_wake();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		report_and_stop();
	end
endmodule
